/* File: hdl/can_btec_pkg.sv */
/*
 * Shared constants and types for the CAN bit-timing and error-confinement
 * block: register offsets, field positions, limits and the protocol context.
 * Assumes a 20 MHz oscillator clock and an 8-bit register port.
 */
// How it works
// - Timing registers take writes only while configuration mode is on.
// - Quantum lasts two times prescaler plus one oscillator periods.
// - Jump width code 00 to 11 gives one to four quanta.
// - Propagation segment is propagation field plus one quanta.
// - First phase segment is its field plus one quanta.
// - Triple sample takes majority of three half-quantum spaced samples.
// - Select bit picks phase two from register or max(phase one, 2).
// - Phase two field plus one quanta; host keeps it two or more.
// - Clock pin shows frame start or divided clock when enabled.
// - Wake filter bit enables or disables the wake line filter.
// - Receiver compares computed CRC with received CRC, errors on mismatch.
// - Transmitter errors when acknowledge slot stays recessive.
// - Dominant level in delimiters, end of frame or interframe is form error.
// - Transmitter flags read-back mismatch, except recessive sent in arbitration and any ack slot.
// - Six equal bits from frame start to CRC delimiter is stuff error.
// - Any error aborts transmission and asks for retransmission.
// - Error-active below 128 on both counters, passive otherwise.
// - Active error frames dominant, passive error frames recessive.
// - Transmit counter past 255 means bus-off; no transmit or receive.
// - Bus-off ends alone after 128 runs of 11 recessive bits.
// - Warning flag set at 96 on either counter, cleared when both below.
// - Counters follow CAN update rules; transmit count readable, read-only.
// - Receive count is a read-only register resetting to zero.
// - Passive and warning flags follow their counter thresholds.
// - Bus-off flag set past 255, cleared after bus recovery.
package can_btec_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_TX_ERR_COUNT = 8'h1C;
    localparam logic [7:0] ADDR_RX_ERR_COUNT = 8'h1D;
    localparam logic [7:0] ADDR_CONFIG_THREE = 8'h28;
    localparam logic [7:0] ADDR_CONFIG_TWO = 8'h29;
    localparam logic [7:0] ADDR_CONFIG_ONE = 8'h2A;
    localparam logic [7:0] ADDR_ERROR_FLAGS = 8'h2D;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] CONFIG_THREE_WMASK = 8'hC7;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int SJW_HI = 7;
    localparam int SJW_LO = 6;
    localparam int BRP_HI = 5;
    localparam int PHASE_TWO_SRC_BIT = 7;
    localparam int TRIPLE_SAMPLE_BIT = 6;
    localparam int PHASE_ONE_HI = 5;
    localparam int PHASE_ONE_LO = 3;
    localparam int PROP_HI = 2;
    localparam int SOF_SELECT_BIT = 7;
    localparam int WAKE_FILTER_BIT = 6;
    localparam int PHASE_TWO_HI = 2;
    localparam int FLAG_BUS_OFF = 5;
    localparam int FLAG_TX_PASSIVE = 4;
    localparam int FLAG_RX_PASSIVE = 3;
    localparam int FLAG_TX_WARNING = 2;
    localparam int FLAG_RX_WARNING = 1;
    localparam int FLAG_ERR_WARNING = 0;

    // ---------------------------------------------------------------
    // Limits and counts
    // ---------------------------------------------------------------
    localparam logic [7:0] PASSIVE_LIMIT = 8'h80;
    localparam logic [7:0] WARNING_LIMIT = 8'h60;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [8:0] TX_ERR_STEP = 9'h008;
    localparam logic [7:0] RX_RESTORE = 8'h77;
    localparam logic [7:0] RECOVERY_RUNS = 8'h80;
    localparam logic [3:0] RECESSIVE_RUN = 4'hB;
    localparam logic [2:0] STUFF_LIMIT = 3'h6;
    localparam logic [4:0] IPT_HALVES = 5'h04;
    localparam logic [14:0] CRC_POLY = 15'h4599;
    localparam int CLK_PERIOD_NS = 50;
    localparam int WAKE_FILTER_NS = 100;
    localparam int WAKE_FILTER_CYC =
        (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        FLD_IDLE = 4'h0, FLD_SOF = 4'h1, FLD_ARB = 4'h2, FLD_CTRL = 4'h3,
        FLD_DATA = 4'h4, FLD_CRC = 4'h5, FLD_CRC_DELIM = 4'h6,
        FLD_ACK_SLOT = 4'h7, FLD_ACK_DELIM = 4'h8, FLD_EOF = 4'h9,
        FLD_IFS = 4'hA, FLD_ERROR = 4'hB
    } field_t;

    typedef enum logic [1:0] {
        PH_SYNC = 2'b00, PH_PROP = 2'b01, PH_PS1 = 2'b10, PH_PS2 = 2'b11
    } phase_t;

    typedef struct packed {
        field_t field;
        logic transmitting;
        logic tx_bit;
        logic stuff_bit;
        logic frame_ok;
    } frame_ctx_t;

    typedef struct packed {
        logic crc_err;
        logic ack_err;
        logic form_err;
        logic bit_err;
        logic stuff_err;
    } err_status_t;

endpackage

/* File: hdl/sync2.sv */
/*
 * Two-flop synchroniser for one asynchronous level.
 * Assumes the input changes slowly relative to clk.
 */
module sync2 (
    input wire logic clk,
    input wire logic rstn,
    input wire logic din,
    output logic dout
);
    logic meta_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= 1'b1;
            dout <= 1'b1;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule

/* File: hdl/crc15.sv */
/*
 * CAN CRC-15 shift register, one bit per enable.
 * Assumes the caller clears it before each frame.
 */
module crc15 (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clear,
    input wire logic enable,
    input wire logic bit_in,
    output logic [14:0] crc
);
    import can_btec_pkg::*;

    logic feedback;
    logic [14:0] shifted;

    assign feedback = bit_in ^ crc[14];
    assign shifted = {crc[13:0], 1'b0};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            crc <= 15'h0000;
        end else if (clear) begin
            crc <= 15'h0000;
        end else if (enable) begin
            crc <= feedback ? (shifted ^ CRC_POLY) : shifted;
        end
    end
endmodule

/* File: hdl/can_bit_timing_error_confinement.sv */
/*
 * Bit timing, sampling, error detection and error confinement of a CAN
 * controller, with its configuration and counter registers.
 * Assumes a protocol engine on clk supplies the frame context per bit,
 * stable across each sample point, and that clk is the oscillator input.
 */
module can_bit_timing_error_confinement (
    input wire logic clk,
    input wire logic rstn,
    input wire logic bus_receive_pin,
    input wire logic config_mode,
    input wire logic clock_output_enable,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    output logic [7:0] reg_rdata,
    input wire can_btec_pkg::frame_ctx_t ctx,
    output logic sample_strobe,
    output logic rx_bit,
    output logic bit_start,
    output can_btec_pkg::err_status_t err,
    output logic error_frame_req,
    output logic error_frame_level,
    output logic retransmit_req,
    output logic bus_off,
    output logic clock_output_pin,
    output logic bus_wake
);
    import can_btec_pkg::*;

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    logic [7:0] cfg_one_reg, cfg_two_reg, cfg_three_reg;
    logic [7:0] tec_reg, tec_next, rec_reg, rec_next;
    logic bus_off_reg, bus_off_next;
    logic wr_one, wr_two, wr_three;

    assign wr_one = reg_write && config_mode
                    && reg_addr == ADDR_CONFIG_ONE;
    assign wr_two = reg_write && config_mode
                    && reg_addr == ADDR_CONFIG_TWO;
    assign wr_three = reg_write && config_mode
                      && reg_addr == ADDR_CONFIG_THREE;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_one_reg <= CONFIG_RESET;
            cfg_two_reg <= CONFIG_RESET;
            cfg_three_reg <= CONFIG_RESET;
        end else begin
            if (wr_one) cfg_one_reg <= reg_wdata;
            if (wr_two) cfg_two_reg <= reg_wdata;
            if (wr_three) cfg_three_reg <= reg_wdata & CONFIG_THREE_WMASK;
        end
    end

    // ---------------------------------------------------------------
    // Register read and error flags
    // ---------------------------------------------------------------
    logic [7:0] flags;
    logic tx_passive, rx_passive, tx_warning, rx_warning;

    assign tx_passive = tec_reg >= PASSIVE_LIMIT;
    assign rx_passive = rec_reg >= PASSIVE_LIMIT;
    assign tx_warning = tec_reg >= WARNING_LIMIT;
    assign rx_warning = rec_reg >= WARNING_LIMIT;

    always_comb begin
        flags = 8'h00;
        flags[FLAG_BUS_OFF] = bus_off_reg;
        flags[FLAG_TX_PASSIVE] = tx_passive;
        flags[FLAG_RX_PASSIVE] = rx_passive;
        flags[FLAG_TX_WARNING] = tx_warning;
        flags[FLAG_RX_WARNING] = rx_warning;
        flags[FLAG_ERR_WARNING] = tx_warning || rx_warning;
    end

    assign reg_rdata =
        (reg_addr == ADDR_TX_ERR_COUNT) ? tec_reg :
        (reg_addr == ADDR_RX_ERR_COUNT) ? rec_reg :
        (reg_addr == ADDR_CONFIG_ONE) ? cfg_one_reg :
        (reg_addr == ADDR_CONFIG_TWO) ? cfg_two_reg :
        (reg_addr == ADDR_CONFIG_THREE) ? cfg_three_reg :
        (reg_addr == ADDR_ERROR_FLAGS) ? flags : 8'h00;

    // ---------------------------------------------------------------
    // Segment lengths in half quanta
    // ---------------------------------------------------------------
    logic [5:0] quantum_prescaler;
    logic [4:0] sjw_h, prop_h, ps1_base_h, ps2_base_h;
    logic [2:0] ph1_field, ph2_field;

    assign quantum_prescaler = cfg_one_reg[BRP_HI:0];
    assign ph1_field = cfg_two_reg[PHASE_ONE_HI:PHASE_ONE_LO];
    assign ph2_field = cfg_three_reg[PHASE_TWO_HI:0];
    assign sjw_h = {2'b00, cfg_one_reg[SJW_HI:SJW_LO], 1'b0}
                   + 5'h02;
    assign prop_h = {1'b0, cfg_two_reg[PROP_HI:0], 1'b0} + 5'h02;
    assign ps1_base_h = {1'b0, ph1_field, 1'b0} + 5'h02;
    assign ps2_base_h = cfg_two_reg[PHASE_TWO_SRC_BIT]
        ? {1'b0, ph2_field, 1'b0} + 5'h02
        : (ps1_base_h > IPT_HALVES ? ps1_base_h : IPT_HALVES);

    // ---------------------------------------------------------------
    // Half-quantum prescaler and phase sequencer
    // ---------------------------------------------------------------
    logic [5:0] div_reg;
    logic hq_tick;
    phase_t phase_reg, phase_next;
    logic [4:0] seg_reg, seg_next, ext_reg, ext_next, cut_reg, cut_next;
    logic [4:0] seg_len, ps2_left, elapsed;
    logic synced_reg, synced_next, restart;
    logic rx_sync, rx_prev_reg, fall_edge, sample_now, bit_end;
    logic [1:0] hist_reg;
    logic bit_val, rx_bit_reg;

    sync2 rx_sync_inst (
        .clk(clk),
        .rstn(rstn),
        .din(bus_receive_pin),
        .dout(rx_sync)
    );

    // Two half-quantum ticks per quantum, so quantum = 2*(brp+1) clocks
    assign hq_tick = div_reg == quantum_prescaler;

    always_comb begin
        case (phase_reg)
            PH_SYNC: seg_len = 5'h02;
            PH_PROP: seg_len = prop_h;
            PH_PS1: seg_len = ps1_base_h + ext_reg;
            default: seg_len = ps2_base_h - cut_reg;
        endcase
    end

    assign ps2_left = seg_len - seg_reg;
    assign elapsed = (phase_reg == PH_PROP) ? seg_reg : prop_h + seg_reg;
    assign fall_edge = rx_prev_reg && !rx_sync && rx_bit_reg
                       && !synced_reg;
    assign sample_now = hq_tick && phase_reg == PH_PS1
                        && seg_reg == seg_len - 5'h01;
    assign bit_end = hq_tick && phase_reg == PH_PS2
                     && seg_reg >= seg_len - 5'h01;

    always_comb begin
        phase_next = phase_reg;
        seg_next = seg_reg;
        ext_next = ext_reg;
        cut_next = cut_reg;
        synced_next = synced_reg;
        restart = 1'b0;
        if (fall_edge && (ctx.field == FLD_IDLE
                          || (phase_reg == PH_PS2 && ps2_left <= sjw_h))) begin
            // Hard sync, or phase error small enough to absorb fully
            restart = 1'b1;
            phase_next = PH_SYNC;
            seg_next = 5'h00;
            ext_next = 5'h00;
            cut_next = 5'h00;
            synced_next = 1'b1;
        end else if (fall_edge && phase_reg == PH_PS2) begin
            cut_next = sjw_h;
            synced_next = 1'b1;
        end else if (fall_edge && phase_reg != PH_SYNC
                     && !ctx.transmitting) begin
            ext_next = elapsed < sjw_h ? elapsed : sjw_h;
            synced_next = 1'b1;
        end else if (bit_end) begin
            phase_next = PH_SYNC;
            seg_next = 5'h00;
            ext_next = 5'h00;
            cut_next = 5'h00;
            synced_next = 1'b0;
        end else if (hq_tick) begin
            if (seg_reg >= seg_len - 5'h01) begin
                phase_next = phase_t'(phase_reg + 2'b01);
                seg_next = 5'h00;
            end else begin
                seg_next = seg_reg + 5'h01;
            end
        end
    end

    // Majority over the two previous half-quantum samples and this one
    assign bit_val = cfg_two_reg[TRIPLE_SAMPLE_BIT]
        ? (hist_reg[1] & hist_reg[0]) | (hist_reg[1] & rx_sync)
          | (hist_reg[0] & rx_sync)
        : rx_sync;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_reg <= 6'h00;
            phase_reg <= PH_SYNC;
            seg_reg <= 5'h00;
            ext_reg <= 5'h00;
            cut_reg <= 5'h00;
            synced_reg <= 1'b0;
            rx_prev_reg <= 1'b1;
            hist_reg <= 2'b11;
            rx_bit_reg <= 1'b1;
            sample_strobe <= 1'b0;
            bit_start <= 1'b0;
        end else begin
            div_reg <= (hq_tick || restart) ? 6'h00 : div_reg + 6'h01;
            phase_reg <= phase_next;
            seg_reg <= seg_next;
            ext_reg <= ext_next;
            cut_reg <= cut_next;
            synced_reg <= synced_next;
            rx_prev_reg <= rx_sync;
            if (hq_tick) hist_reg <= {hist_reg[0], rx_sync};
            if (sample_now) rx_bit_reg <= bit_val;
            sample_strobe <= sample_now;
            bit_start <= bit_end || restart;
        end
    end

    assign rx_bit = rx_bit_reg;

    // ---------------------------------------------------------------
    // Error detection at the sample point
    // ---------------------------------------------------------------
    logic in_stuff_region, in_crc_region, form_field, arb_or_ack;
    logic [2:0] run_reg;
    logic last_reg;
    logic [14:0] crc_calc, crc_rx_reg;
    logic active;
    err_status_t det;
    logic any_err;

    assign active = sample_now && !bus_off_reg;
    assign in_stuff_region = ctx.field inside {FLD_SOF, FLD_ARB, FLD_CTRL,
                                               FLD_DATA, FLD_CRC};
    assign in_crc_region = ctx.field inside {FLD_SOF, FLD_ARB, FLD_CTRL,
                                             FLD_DATA};
    assign form_field = ctx.field inside {FLD_CRC_DELIM, FLD_ACK_DELIM,
                                          FLD_EOF, FLD_IFS};
    assign arb_or_ack = ctx.field inside {FLD_ARB, FLD_ACK_SLOT};

    crc15 crc_inst (
        .clk(clk),
        .rstn(rstn),
        .clear(ctx.field == FLD_IDLE),
        .enable(active && in_crc_region && !ctx.stuff_bit),
        .bit_in(bit_val),
        .crc(crc_calc)
    );

    always_comb begin
        det.crc_err = !ctx.transmitting && ctx.field == FLD_CRC_DELIM
                      && crc_rx_reg != crc_calc;
        det.ack_err = ctx.transmitting && ctx.field == FLD_ACK_SLOT
                      && bit_val;
        det.form_err = form_field && !bit_val;
        det.bit_err = ctx.transmitting && bit_val != ctx.tx_bit
                      && !(ctx.tx_bit && arb_or_ack)
                      && ctx.field != FLD_IDLE
                      && ctx.field != FLD_ERROR
                      && ctx.field != FLD_ACK_SLOT;
        det.stuff_err = in_stuff_region && bit_val == last_reg
                        && run_reg == STUFF_LIMIT - 3'h1;
    end

    assign any_err = active && (det != '0);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_reg <= 3'h0;
            last_reg <= 1'b1;
            crc_rx_reg <= 15'h0000;
            err <= '0;
            error_frame_req <= 1'b0;
            retransmit_req <= 1'b0;
        end else begin
            if (ctx.field == FLD_IDLE || !in_stuff_region) begin
                run_reg <= 3'h0;
            end else if (active) begin
                run_reg <= (bit_val == last_reg) ? run_reg + 3'h1 : 3'h1;
            end
            if (active) last_reg <= bit_val;
            if (active && ctx.field == FLD_CRC && !ctx.stuff_bit) begin
                crc_rx_reg <= {crc_rx_reg[13:0], bit_val};
            end
            err <= active ? det : '0;
            error_frame_req <= any_err;
            retransmit_req <= any_err && ctx.transmitting;
        end
    end

    // Passive nodes signal errors with recessive level
    assign error_frame_level = tx_passive || rx_passive;

    // ---------------------------------------------------------------
    // Error counters and bus-off recovery
    // ---------------------------------------------------------------
    logic [8:0] tec_sum;
    logic [3:0] rec_run_reg, rec_run_next;
    logic [7:0] occur_reg, occur_next;
    logic run_done;

    assign tec_sum = {1'b0, tec_reg} + TX_ERR_STEP;
    assign run_done = rec_run_reg == RECESSIVE_RUN - 4'h1;

    always_comb begin
        tec_next = tec_reg;
        rec_next = rec_reg;
        bus_off_next = bus_off_reg;
        rec_run_next = rec_run_reg;
        occur_next = occur_reg;
        if (bus_off_reg) begin
            if (sample_now) begin
                rec_run_next = (bit_val && !run_done)
                               ? rec_run_reg + 4'h1 : 4'h0;
                if (bit_val && run_done) begin
                    occur_next = occur_reg + 8'h01;
                    if (occur_reg == RECOVERY_RUNS - 8'h01) begin
                        tec_next = 8'h00;
                        rec_next = 8'h00;
                        bus_off_next = 1'b0;
                        occur_next = 8'h00;
                    end
                end
            end
        end else if (any_err && ctx.transmitting) begin
            if (tec_sum > {1'b0, COUNT_MAX}) begin
                tec_next = COUNT_MAX;
                bus_off_next = 1'b1;
            end else begin
                tec_next = tec_sum[7:0];
            end
        end else if (any_err) begin
            if (rec_reg != COUNT_MAX) rec_next = rec_reg + 8'h01;
        end else if (ctx.frame_ok && ctx.transmitting) begin
            if (tec_reg != 8'h00) tec_next = tec_reg - 8'h01;
        end else if (ctx.frame_ok) begin
            if (rec_reg >= PASSIVE_LIMIT) rec_next = RX_RESTORE;
            else if (rec_reg != 8'h00) rec_next = rec_reg - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tec_reg <= 8'h00;
            rec_reg <= 8'h00;
            bus_off_reg <= 1'b0;
            rec_run_reg <= 4'h0;
            occur_reg <= 8'h00;
        end else begin
            tec_reg <= tec_next;
            rec_reg <= rec_next;
            bus_off_reg <= bus_off_next;
            rec_run_reg <= rec_run_next;
            occur_reg <= occur_next;
        end
    end

    assign bus_off = bus_off_reg;

    // ---------------------------------------------------------------
    // Clock output pin and wake filter
    // ---------------------------------------------------------------
    logic clkdiv_reg, clock_output_pin_reg, wake_reg;
    logic [3:0] wake_cnt_reg;
    logic wake_full;

    assign wake_full = wake_cnt_reg >= 4'(WAKE_FILTER_CYC);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clkdiv_reg <= 1'b0;
            clock_output_pin_reg <= 1'b0;
            wake_cnt_reg <= 4'h0;
            wake_reg <= 1'b0;
        end else begin
            clkdiv_reg <= !clkdiv_reg;
            clock_output_pin_reg <= clock_output_enable
                && (cfg_three_reg[SOF_SELECT_BIT]
                    ? ctx.field == FLD_SOF : clkdiv_reg);
            if (rx_sync) wake_cnt_reg <= 4'h0;
            else if (!wake_full) wake_cnt_reg <= wake_cnt_reg + 4'h1;
            wake_reg <= cfg_three_reg[WAKE_FILTER_BIT]
                        ? wake_full : !rx_sync;
        end
    end

    assign clock_output_pin = clock_output_pin_reg;
    assign bus_wake = wake_reg;

endmodule

/* File: bench/can_bus_node.sv */
/* Another node on the bus: a wired-and line with a pull-up.
   Assumes the bench pulls it dominant only while that node sends. */
module can_bus_node (
    input wire logic dominant,
    output logic bus_line
);
    timeunit 1ns;
    timeprecision 1ns;
    // Released line goes back to recessive
    assign bus_line = ~dominant;
endmodule

/* File: bench/can_bit_timing_error_confinement_props.sv */
/* Port checks of the bit-timing and error block.
   Assumes one clock domain and the package register map. */
module can_btec_props (
    input logic clk,
    input logic rstn,
    input logic config_mode,
    input logic [7:0] reg_addr,
    input logic reg_write,
    input logic [7:0] reg_rdata,
    input logic sample_strobe,
    input can_btec_pkg::err_status_t err,
    input logic error_frame_req,
    input logic error_frame_level,
    input logic retransmit_req,
    input logic bus_off
);
    timeunit 1ns;
    timeprecision 1ns;
    import can_btec_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire flags = reg_addr == ADDR_ERROR_FLAGS;
    chk_err_req:
        assert property (err != '0 |-> error_frame_req) else $error("no req");
    chk_on_sample:
        assert property (error_frame_req |-> sample_strobe) else $error("off");
    chk_retx_req:
        assert property (retransmit_req |-> error_frame_req)
            else $error("retx");
    chk_err_level:
        assert property (flags && !bus_off |-> error_frame_level ==
            (reg_rdata[4] | reg_rdata[3])) else $error("error level");
    chk_warn_flag:
        assert property (flags |->
            reg_rdata[0] == (reg_rdata[1] | reg_rdata[2]))
            else $error("warning flag");
    chk_off_flag:
        assert property (flags |-> reg_rdata[5] == bus_off)
            else $error("flag");
    chk_off_quiet:
        assert property (bus_off && $past(bus_off) |-> !error_frame_req)
            else $error("error while bus-off");
    chk_cfg_gate:
        assert property (reg_write && !config_mode
            && reg_addr == ADDR_CONFIG_ONE
            ##1 reg_addr == ADDR_CONFIG_ONE |-> $stable(reg_rdata))
            else $error("write outside configuration");
endmodule
bind can_bit_timing_error_confinement can_btec_props chk (.clk, .rstn,
    .config_mode, .reg_addr, .reg_write, .reg_rdata, .sample_strobe, .err,
    .error_frame_req, .error_frame_level, .retransmit_req, .bus_off);

/* File: bench/can_bit_timing_error_confinement_test.sv */
/* Bench: register table, bit lengths, errors, bus-off and recovery.
   Assumes the bus idles recessive unless the node model pulls it. */
module can_bit_timing_error_confinement_test;
    timeunit 1ns;
    timeprecision 1ns;
    import can_btec_pkg::*;
    logic clk = 0, rstn = 0, config_mode = 0, clock_output_enable = 0;
    logic reg_write = 0, dom = 0, bus_receive_pin, rx_bit, bit_start;
    logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata;
    logic sample_strobe, error_frame_req, error_frame_level;
    logic retransmit_req, bus_off, clock_output_pin, bus_wake;
    frame_ctx_t ctx = '{FLD_IDLE, 0, 1, 0, 0};
    err_status_t err;
    int num_errors = 0, checks = 0, cyc = 0, n;
    logic [31:0] regs [10] = '{32'h2ac5_01c5, 32'h2a00_00c5,
        32'h2a00_0100, 32'h29a5_01a5, 32'h2900_0100, 32'h28ff_01c7,
        32'h2800_0100, 32'h1c55_0100, 32'h1d55_0100, 32'h3a5a_0100};
    logic [31:0] bits [5] = '{32'h0100_0014, 32'h0080_0716,
        32'h003f_0032, 32'h0008_000c, 32'h0000_000a};
    can_bus_node node (.dominant(dom), .bus_line(bus_receive_pin));
    can_bit_timing_error_confinement uut (.clk, .rstn, .bus_receive_pin,
        .config_mode, .clock_output_enable, .reg_addr, .reg_wdata,
        .reg_write, .reg_rdata, .ctx, .sample_strobe, .rx_bit, .bit_start,
        .err, .error_frame_req, .error_frame_level, .retransmit_req,
        .bus_off, .clock_output_pin, .bus_wake);
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            test_done;
        end
    end
    task tick(int k);
        repeat (k) @(posedge clk) #5;
    endtask
    task chk(logic [15:0] got, logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(logic [7:0] a, logic [7:0] d, logic m);
        {reg_addr, reg_wdata, config_mode, reg_write} = {a, d, m, 1'b1};
        tick(1);
        reg_write = 0;
        tick(1);
    endtask
    task rd(logic [7:0] a, logic [7:0] e);
        reg_addr = a;
        tick(1);
        chk(reg_rdata, e);
    endtask
    task automatic wt(ref logic s);
        for (int i = 0; i < 300 && s !== 1'b1; i++) tick(1);
    endtask
    task automatic errs(int k);
        repeat (k) begin
            wt(error_frame_req);
            tick(1);
        end
    endtask
    task test_done;
        $display("checks %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        tick(8);
        rstn = 1;
        foreach (regs[i]) rd(regs[i][31:24], 8'h00);
        rd(ADDR_ERROR_FLAGS, 8'h00);
        foreach (regs[i]) begin
            wr(regs[i][31:24], regs[i][23:16], regs[i][8]);
            rd(regs[i][31:24], regs[i][7:0]);
        end
        $display("registers done");
        foreach (bits[i]) begin
            wr(ADDR_CONFIG_ONE, bits[i][31:24], 1'b1);
            wr(ADDR_CONFIG_TWO, bits[i][23:16], 1'b1);
            wr(ADDR_CONFIG_THREE, bits[i][15:8], 1'b1);
            wt(sample_strobe);
            tick(1);
            wt(sample_strobe);
            tick(1);
            for (n = 1; sample_strobe !== 1'b1 && n < 300; n++) tick(1);
            chk(16'(n), 16'(bits[i][7:0]));
        end
        $display("bit lengths done");
        clock_output_enable = 1;
        wr(ADDR_CONFIG_THREE, 8'h80, 1'b1);
        config_mode = 0;
        ctx.field = FLD_SOF;
        tick(2);
        chk(clock_output_pin, 1'b1);
        ctx.field = FLD_EOF;
        dom = 1;
        wt(error_frame_req);
        chk({error_frame_level, retransmit_req, err, bus_wake,
            clock_output_pin}, 9'h012);
        dom = 0;
        tick(1);
        rd(ADDR_RX_ERR_COUNT, 8'h01);
        wt(sample_strobe);
        ctx.field = FLD_DATA;
        for (n = 0; error_frame_req !== 1'b1 && n < 99; n += sample_strobe)
            tick(1);
        chk({n[7:0], 3'h0, err}, 16'h0601);
        tick(1);
        $display("form and stuff done");
        ctx = '{FLD_ACK_SLOT, 1, 1, 0, 0};
        errs(12);
        rd(ADDR_TX_ERR_COUNT, 8'h60);
        rd(ADDR_ERROR_FLAGS, 8'h05);
        errs(4);
        rd(ADDR_ERROR_FLAGS, 8'h15);
        chk(error_frame_level, 1'b1);
        errs(16);
        rd(ADDR_TX_ERR_COUNT, 8'hff);
        rd(ADDR_ERROR_FLAGS, 8'h35);
        ctx = '{FLD_IDLE, 0, 1, 0, 0};
        for (n = 0; bus_off === 1'b1 && n < 16000; n++) tick(1);
        chk(n > 14000 && n < 14200, 1'b1);
        rd(ADDR_RX_ERR_COUNT, 8'h00);
        rd(ADDR_ERROR_FLAGS, 8'h00);
        $display("bus-off done");
        ctx = '{FLD_SOF, 0, 1, 0, 0};
        tick(1);
        wt(sample_strobe);
        ctx.field = FLD_CRC_DELIM;
        wt(error_frame_req);
        chk({rx_bit, err}, 6'h30);
        tick(1);
        ctx = '{FLD_CTRL, 1, 0, 0, 0};
        wt(error_frame_req);
        chk({retransmit_req, err}, 6'h22);
        $display("crc and bit error done");
        test_done;
    end
endmodule
